/* File: tdm_pcm_serial_port_regs.vh */
`ifndef TDM_PCM_SERIAL_PORT_REGS_VH
`define TDM_PCM_SERIAL_PORT_REGS_VH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define TDM_SLOTS          32
`define TDM_SLOT_W         5
`define TDM_SLOT_BITS      8
`define TDM_BITPOS_W       3
`define TDM_FRAME_POS_W    8
`define TDM_LAST_BIT       3'h7
`define TDM_FIRST_BIT      3'h0

// ----------------------------------------
// control field positions and resets
// ----------------------------------------
`define TDM_CTRL_ODE_BIT   6
`define TDM_IDLE_LEVEL     1'b1
`define TDM_SLOT_RESET     5'h00

// ----------------------------------------
// pin sampling and timing counts
// ----------------------------------------
`define TDM_SYNC_STAGES    3
`define TDM_PIN_COUNT      5
`define TDM_CLK_PERIOD_PS  5000
`define TDM_C4_PERIOD_PS   244140
`define TDM_C4_PER_BIT     2
`define TDM_FMT_RUN        4
`define TDM_RUN_W          3

`endif

/* File: tdm_pin_sync.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// three stage pin filter
// ----------------------------------------
module tdm_pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             srst,
	input  wire [WIDTH-1:0] pin,
	output wire [WIDTH-1:0] level
);

	reg [WIDTH-1:0] s1_reg;
	reg [WIDTH-1:0] s2_reg;
	reg [WIDTH-1:0] s3_reg;
	reg [WIDTH-1:0] level_reg;

	always @(posedge clk) begin
		s1_reg <= pin;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// a change counts once stages two and three agree
			always @(posedge clk) begin
				if (srst) begin
					level_reg[i] <= 1'b0;
				end else if (s2_reg[i] == s3_reg[i]) begin
					level_reg[i] <= s3_reg[i];
				end
			end
		end
	endgenerate

	assign level = level_reg;

endmodule

`default_nettype wire

/* File: tdm_pcm_serial_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "tdm_pcm_serial_port_regs.vh"

module tdm_pcm_serial_port #(
	parameter FMT_RUN = `TDM_FMT_RUN
) (
	input  wire                    clk,
	input  wire                    srst,
	input  wire                    bit_clock_4m,
	input  wire                    frame_pulse_in,
	input  wire                    rin_in,
	input  wire                    sin_in,
	input  wire                    output_drive_enable,
	input  wire                    ode_ctrl_bit,
	input  wire [7:0]              sout_data,
	input  wire [7:0]              rout_data,
	output reg                     sout_out,
	output reg                     sout_oe_n,
	output reg                     rout_out,
	output reg                     rout_oe_n,
	output reg  [7:0]              rin_byte,
	output reg  [7:0]              sin_byte,
	output reg  [`TDM_SLOT_W-1:0]  rx_slot,
	output reg                     rx_valid,
	output reg  [`TDM_SLOT_W-1:0]  next_slot,
	output reg                     tx_load,
	output reg                     gci_mode,
	output reg                     frame_locked
);

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	wire [`TDM_PIN_COUNT-1:0] pins_lvl;
	wire                      c4_lvl;
	wire                      fp_lvl;
	wire                      rin_lvl;
	wire                      sin_lvl;
	wire                      ode_lvl;

	tdm_pin_sync #(
		.WIDTH (`TDM_PIN_COUNT)
	) u_sync (
		.clk   (clk),
		.srst  (srst),
		.pin   ({output_drive_enable, sin_in, rin_in, frame_pulse_in, bit_clock_4m}),
		.level (pins_lvl)
	);

	assign c4_lvl  = pins_lvl[0];
	assign fp_lvl  = pins_lvl[1];
	assign rin_lvl = pins_lvl[2];
	assign sin_lvl = pins_lvl[3];
	assign ode_lvl = pins_lvl[4];

	// ----------------------------------------
	// bit clock edges
	// ----------------------------------------
	reg  c4_prev_reg;
	wire c4_rise;

	always @(posedge clk) begin
		if (srst) begin
			c4_prev_reg <= 1'b0;
		end else begin
			c4_prev_reg <= c4_lvl;
		end
	end

	assign c4_rise = c4_lvl & ~c4_prev_reg;

	// ----------------------------------------
	// frame pulse format
	// ----------------------------------------
	reg                   run_level_reg;
	reg [`TDM_RUN_W-1:0]  run_cnt_reg;
	reg                   fmt_valid_reg;
	reg                   fp_act_prev_reg;
	wire                  fp_act;
	wire                  frame_start;

	always @(posedge clk) begin
		if (srst) begin
			run_level_reg <= 1'b0;
			run_cnt_reg   <= {`TDM_RUN_W{1'b0}};
			fmt_valid_reg <= 1'b0;
			gci_mode      <= 1'b0;
		end else if (c4_rise) begin
			if (fp_lvl != run_level_reg) begin
				run_level_reg <= fp_lvl;
				run_cnt_reg   <= {`TDM_RUN_W{1'b0}};
			end else if (run_cnt_reg == FMT_RUN[`TDM_RUN_W-1:0] - 1'b1) begin
				fmt_valid_reg <= 1'b1;
				gci_mode      <= ~fp_lvl;
			end else begin
				run_cnt_reg <= run_cnt_reg + 1'b1;
			end
		end
	end

	assign fp_act      = gci_mode ? fp_lvl : ~fp_lvl;
	assign frame_start = c4_rise & fmt_valid_reg & fp_act_prev_reg & ~fp_act;

	always @(posedge clk) begin
		if (srst) begin
			fp_act_prev_reg <= 1'b0;
		end else if (c4_rise) begin
			fp_act_prev_reg <= fmt_valid_reg & fp_act;
		end
	end

	// ----------------------------------------
	// frame position
	// ----------------------------------------
	reg                        phase_reg;
	reg [`TDM_FRAME_POS_W-1:0] pos_reg;
	wire [`TDM_FRAME_POS_W-1:0] pos_next;
	wire                       drive_edge;
	wire                       sample_edge;
	wire                       slot_first;

	assign pos_next    = frame_start ? {`TDM_FRAME_POS_W{1'b0}} : pos_reg + 1'b1;
	assign drive_edge  = frame_start | (c4_rise & frame_locked & phase_reg);
	assign sample_edge = c4_rise & frame_locked & ~phase_reg & ~frame_start;
	assign slot_first  = pos_next[`TDM_BITPOS_W-1:0] == `TDM_FIRST_BIT;

	always @(posedge clk) begin
		if (srst) begin
			phase_reg    <= 1'b0;
			pos_reg      <= {`TDM_FRAME_POS_W{1'b0}};
			frame_locked <= 1'b0;
		end else if (drive_edge) begin
			phase_reg    <= 1'b0;
			pos_reg      <= pos_next;
			frame_locked <= 1'b1;
		end else if (sample_edge) begin
			phase_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// transmit shifters
	// ----------------------------------------
	reg [7:0] sout_sh_reg;
	reg [7:0] rout_sh_reg;

	// both ports send: sout and rout shift out together, msb first
	always @(posedge clk) begin
		if (srst) begin
			sout_sh_reg <= 8'hFF;
			rout_sh_reg <= 8'hFF;
			sout_out    <= `TDM_IDLE_LEVEL;
			rout_out    <= `TDM_IDLE_LEVEL;
			tx_load     <= 1'b0;
			next_slot   <= `TDM_SLOT_RESET;
		end else begin
			tx_load <= 1'b0;
			if (drive_edge && slot_first) begin
				sout_sh_reg <= sout_data;
				rout_sh_reg <= rout_data;
				sout_out    <= sout_data[7];
				rout_out    <= rout_data[7];
				tx_load     <= 1'b1;
				next_slot   <= pos_next[`TDM_FRAME_POS_W-1:`TDM_BITPOS_W] + 1'b1;
			end else if (drive_edge) begin
				sout_sh_reg <= {sout_sh_reg[6:0], 1'b1};
				sout_out    <= sout_sh_reg[6];
				rout_sh_reg <= {rout_sh_reg[6:0], 1'b1};
				rout_out    <= rout_sh_reg[6];
			end
		end
	end

	// ----------------------------------------
	// receive shifters
	// ----------------------------------------
	reg [6:0] rin_sh_reg;
	reg [6:0] sin_sh_reg;

	always @(posedge clk) begin
		if (srst) begin
			rin_sh_reg <= 7'h00;
			sin_sh_reg <= 7'h00;
			rin_byte   <= 8'h00;
			sin_byte   <= 8'h00;
			rx_slot    <= `TDM_SLOT_RESET;
			rx_valid   <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (sample_edge) begin
				rin_sh_reg <= {rin_sh_reg[5:0], rin_lvl};
				sin_sh_reg <= {sin_sh_reg[5:0], sin_lvl};
				if (pos_reg[`TDM_BITPOS_W-1:0] == `TDM_LAST_BIT) begin
					rin_byte <= {rin_sh_reg, rin_lvl};
					sin_byte <= {sin_sh_reg, sin_lvl};
					rx_slot  <= pos_reg[`TDM_FRAME_POS_W-1:`TDM_BITPOS_W];
					rx_valid <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// output drive enable
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			sout_oe_n <= 1'b1;
			rout_oe_n <= 1'b1;
		end else begin
			sout_oe_n <= ~(ode_lvl & ode_ctrl_bit);
			rout_oe_n <= ~(ode_lvl & ode_ctrl_bit);
		end
	end

endmodule

`default_nettype wire

/* File: tdm_pcm_serial_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module tdm_port_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic output_drive_enable,
	input wire logic ode_ctrl_bit,
	input wire logic sout_out,
	input wire logic sout_oe_n,
	input wire logic rout_out,
	input wire logic rout_oe_n,
	input wire logic rx_valid,
	input wire logic tx_load,
	input wire logic gci_mode,
	input wire logic frame_locked
);
	// ------
	// port checks
	// ------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	oe_pair_a: assert property (sout_oe_n == rout_oe_n)
		else $error("enables differ");
	ctrl_off_a: assert property (!ode_ctrl_bit |=> sout_oe_n)
		else $error("ctrl off still driving");
	pin_off_a: assert property ($fell(output_drive_enable) |-> ##[1:6] rout_oe_n)
		else $error("pin off still driving");
	both_on_a: assert property ((ode_ctrl_bit && output_drive_enable) [*7] |=> !sout_oe_n)
		else $error("not driving");
	load_pulse_a: assert property (tx_load |=> !tx_load)
		else $error("load pulse long");
	rx_gap_a: assert property (rx_valid |=> !rx_valid [*8])
		else $error("bytes too close");
	idle_high_a: assert property (!frame_locked |-> sout_out && rout_out)
		else $error("idle not high");
	lock_hold_a: assert property (frame_locked |=> frame_locked)
		else $error("lock lost");
	reset_val_a: assert property (
		disable iff (1'b0) srst |=> rout_oe_n && !gci_mode && !frame_locked)
		else $error("reset values");
endmodule
bind tdm_pcm_serial_port tdm_port_checker chk_i (.clk(clk), .srst(srst),
	.output_drive_enable(output_drive_enable), .ode_ctrl_bit(ode_ctrl_bit), .sout_out(sout_out),
	.sout_oe_n(sout_oe_n), .rout_out(rout_out), .rout_oe_n(rout_oe_n), .rx_valid(rx_valid),
	.tx_load(tx_load), .gci_mode(gci_mode), .frame_locked(frame_locked));
`default_nettype wire

/* File: tdm_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module tdm_far_end (
	input  wire logic       run,
	input  wire logic       gci,
	input  wire logic       sout_out,
	input  wire logic       rout_out,
	output var  logic       c4,
	output var  logic       frame_pulse,
	output var  logic       rin,
	output var  logic       sin,
	output var  logic [7:0] sout_cap,
	output var  logic [7:0] rout_cap,
	output var  logic [4:0] cap_slot,
	output var  logic       cap_stb
);
	logic [7:0] rin_v;
	task automatic tick();
		#40 c4 = 1'b1;
		#40 c4 = 1'b0;
	endtask
	initial begin
		c4 = 1'b0;
		{rin, sin, cap_stb, frame_pulse} = 4'h1;
		forever begin
			wait (run);
			frame_pulse = ~gci;
			repeat (6) tick();
			frame_pulse = gci;
			tick();
			frame_pulse = ~gci;
			// slots of 8 bits msb first
			for (int b = 0; b < 256; b++) begin
				tick();
				cap_stb = 1'b0;
				rin_v = {3'h5, 5'(b / 8)};
				rin = rin_v[7 - b % 8];
				sin = ~rin;
				#40 sout_cap = {sout_cap[6:0], sout_out};
				rout_cap = {rout_cap[6:0], rout_out};
				c4 = 1'b1;
				#40 c4 = 1'b0;
				if (b % 8 == 7) begin
					cap_slot = 5'(b / 8);
					cap_stb = 1'b1;
				end
			end
			rin = ~rin;
			sin = ~sin;
			wait (!run);
		end
	end
endmodule
`default_nettype wire

/* File: tdm_pcm_serial_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tdm_pcm_serial_port_test;
	logic       clk, srst, c4, fp, rin, sin, pin_en, ctrl_en, run, gci, cap_stb;
	logic       sout_out, sout_oe_n, rout_out, rout_oe_n, rx_valid, tx_load;
	logic       gci_mode, frame_locked;
	logic [7:0] sout_data, rout_data, rin_byte, sin_byte, sout_cap, rout_cap;
	logic [4:0] rx_slot, next_slot, cap_slot;
	logic [2:0] rows [5] = '{3'h6, 3'h3, 3'h5, 3'h1, 3'h6};
	int         error_cnt, total_checks, rx_cnt, cap_cnt;
	tdm_pcm_serial_port #(.FMT_RUN(4)) DUT (.clk(clk), .srst(srst), .bit_clock_4m(c4),
		.frame_pulse_in(fp), .rin_in(rin), .sin_in(sin), .output_drive_enable(pin_en),
		.ode_ctrl_bit(ctrl_en), .sout_data(sout_data), .rout_data(rout_data),
		.sout_out(sout_out), .sout_oe_n(sout_oe_n), .rout_out(rout_out), .rout_oe_n(rout_oe_n),
		.rin_byte(rin_byte), .sin_byte(sin_byte), .rx_slot(rx_slot), .rx_valid(rx_valid),
		.next_slot(next_slot), .tx_load(tx_load), .gci_mode(gci_mode), .frame_locked(frame_locked));
	tdm_far_end far_end (.run(run), .gci(gci), .sout_out(sout_out), .rout_out(rout_out), .c4(c4),
		.frame_pulse(fp), .rin(rin), .sin(sin), .sout_cap(sout_cap), .rout_cap(rout_cap),
		.cap_slot(cap_slot), .cap_stb(cap_stb));
	// ------
	// helpers
	// ------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic frame(input logic mode);
		int target;
		target = cap_cnt + 32;
		gci = mode;
		run = 1'b1;
		wait (cap_cnt == target);
		run = 1'b0;
		repeat (20) @(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk) begin
		sout_data <= {3'h2, next_slot};
		rout_data <= {3'h6, next_slot};
	end
	always @(posedge cap_stb) begin
		cap_cnt++;
		check(sout_cap, {3'h2, cap_slot});
		check(rout_cap, {3'h6, cap_slot});
	end
	always @(posedge clk) if (rx_valid) begin
		rx_cnt++;
		check(rin_byte, {3'h5, rx_slot});
		check(sin_byte, ~{3'h5, rx_slot});
	end
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	// ------
	// sequence
	// ------
	initial begin
		{srst, run, gci, pin_en, ctrl_en} = 5'h10;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		foreach (rows[i]) begin
			{pin_en, ctrl_en} = rows[i][2:1];
			repeat (8) @(negedge clk);
			check(8'({sout_oe_n, rout_oe_n}), 8'({2{rows[i][0]}}));
		end
		frame(1'b0);
		check(8'({gci_mode, frame_locked}), 8'h01);
		srst = 1'b1;
		repeat (4) @(negedge clk);
		check(8'({gci_mode, frame_locked, sout_oe_n}), 8'h01);
		srst = 1'b0;
		frame(1'b1);
		check(8'({gci_mode, frame_locked}), 8'h03);
		check(8'(rx_cnt), 8'h40);
		check(8'(cap_cnt), 8'h40);
		close_out();
	end
endmodule
`default_nettype wire
